// >>> logic/bms_op_timer.sv
// Module: busy timer for one long operation
`timescale 1ns/1ns
`default_nettype none
module bms_op_timer
  import bms_pkg::*;
#(
  parameter int CYCLES = COPY_CYCLES
)
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // Handshake
  bms_timer_if.timer tif
);

  initial
  begin
    if (CYCLES < 1 || CYCLES >= (1 << TIMER_WIDTH))
      $error("bms_op_timer: CYCLES out of range");
  end

  typedef struct packed
  {
    bms_timer_state_type     state;
    logic [TIMER_WIDTH-1:0]  count;
    logic                    done;
  } bms_op_state_type;

  bms_op_state_type st_reg;
  bms_op_state_type st_next;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      BMS_IDLE:
      begin
        if (tif.start)
        begin
          st_next.state = BMS_RUN;
          st_next.count = TIMER_WIDTH'(CYCLES - 1);
        end
      end
      BMS_RUN:
      begin
        if (st_reg.count == '0)
        begin
          st_next.state = BMS_IDLE;
          st_next.done  = 1'b1;
        end
        else
          st_next.count = st_reg.count - 1'b1;
      end
      default:
        st_next.state = BMS_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg.state <= BMS_IDLE;
      st_reg.count <= '0;
      st_reg.done  <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  assign tif.busy = (st_reg.state == BMS_RUN);
  assign tif.done = st_reg.done;

endmodule : bms_op_timer
`default_nettype wire

// >>> logic/bms_pkg.sv
// Package: constants and types for the status-page block
package bms_pkg;

  // ==========================================================
  // Addresses
  localparam logic [7:0] BMS_PAGE3_BASE    = 8'h40;
  localparam int         BMS_PAGE3_BYTES   = 8;
  localparam logic [7:0] BMS_TEMP_LSB_ADDR = 8'h60;
  localparam logic [7:0] BMS_TEMP_MSB_ADDR = 8'h61;
  localparam logic [7:0] BMS_STAT_LSB_ADDR = 8'h62;
  localparam logic [7:0] BMS_STAT_MSB_ADDR = 8'h63;

  // ==========================================================
  // Status fields
  localparam int BMS_TEMP_BUSY_BIT = 0;
  localparam int BMS_COPY_BUSY_BIT = 1;
  localparam int BMS_LOCK_BIT      = 2;
  localparam int BMS_VOLT_BUSY_BIT = 3;
  localparam logic [7:0] BMS_STAT_MSB_VALUE = 8'hff;
  localparam logic [7:0] BMS_UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] BMS_BYTE_RESET     = 8'h00;
  localparam logic [2:0] BMS_TEMP_PAD       = 3'h0;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 125;
  localparam int COPY_TIME_MS     = 10;
  localparam int VOLT_CONV_MS     = 10;
  localparam int COPY_CYCLES      = COPY_TIME_MS * 1000 * CLK_MHZ;
  localparam int VOLT_CONV_CYCLES = VOLT_CONV_MS * 1000 * CLK_MHZ;
  localparam int TIMER_WIDTH      = 24;

  // ==========================================================
  // Operation timer states
  typedef enum logic [1:0]
  {
    BMS_IDLE = 2'b01,
    BMS_RUN  = 2'b10
  } bms_timer_state_type;

endpackage : bms_pkg

// >>> logic/bms_status_pages.sv
// Module: page three memory and page four result/status registers
//
// Contract
// - Page three holds eight user bytes: scratchpad copied into SRAM.
// - Page three SRAM has no power-loss retention; contents may be lost.
// - Each finished temperature result lands in registers at 60h-61h.
// - Temperature result is volatile, kept only while powered.
// - Result is 13-bit two's complement, LSB one thirty-second degree.
// - MSB sign and integer; LSB five fraction bits then three zeros.
// - Status at 62h-63h is readable and never host-writable.
// - Status LSB: bit0 temp busy, bit1 copy busy, bit2 lock, bit3 ADC.
// - Status MSB is reserved and reads all ones.
// - Temperature busy high during conversion, low once result valid.
// - Copy busy high while scratchpad copies to EEPROM.
// - Copy lasts two to ten milliseconds; host polls copy busy.
// - Lock flag reads one when the first page is write-protected.
// - Lock flag is held in nonvolatile storage across power loss.
// - Voltage busy high while battery voltage conversion runs.
// - Voltage conversion about ten milliseconds; host waits for busy clear.
// - Convert command starts one voltage measurement, busy meanwhile.
`timescale 1ns/1ns
`default_nettype none
module bms_status_pages
  import bms_pkg::*;
#(
  parameter int COPY_CYCLES_P = COPY_CYCLES,
  parameter int CONV_CYCLES_P = VOLT_CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Memory access from the command layer
  input  wire logic [7:0]  mem_addr,
  input  wire logic        mem_read,
  input  wire logic        scratch_write,
  input  wire logic [2:0]  scratch_index,
  input  wire logic [7:0]  scratch_data,
  input  wire logic        copy_page3,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rvalid,
  // Temperature sensor
  input  wire logic        temp_conv_start,
  input  wire logic        temp_conv_done,
  input  wire logic [12:0] temp_conv_value,
  // Voltage conversion command
  input  wire logic        volt_conv_cmd,
  output logic             volt_conv_done,
  // EEPROM copy request
  input  wire logic        eeprom_copy_start,
  // Nonvolatile lock bit as read from its EEPROM cell
  input  wire logic        first_page_nonvolatile,
  // Status view
  output logic             temp_conv_busy_flag,
  output logic             eeprom_copy_busy_flag,
  output logic             voltage_conv_busy_flag
);

  initial
  begin
    if (COPY_CYCLES_P < 1 || CONV_CYCLES_P < 1)
      $error("bms_status_pages: cycle counts must be positive");
  end

  // ==========================================================
  // State
  typedef struct packed
  {
    logic [7:0]  rdata;
    logic        rvalid;
    logic [15:0] temp;
    logic        temp_busy;
    logic        copy_busy;
    logic        volt_busy;
    logic        volt_done;
    logic        lock;
  } bms_state_type;

  bms_state_type st_reg;
  bms_state_type st_next;

  // Page three storage, no reset on power loss
  logic [7:0] scratch_mem [BMS_PAGE3_BYTES];
  logic [7:0] sram_mem    [BMS_PAGE3_BYTES];

  // ==========================================================
  // Long operation timers
  bms_timer_if copy_tif ();
  bms_timer_if volt_tif ();

  assign copy_tif.start = eeprom_copy_start && !copy_tif.busy;
  assign volt_tif.start = volt_conv_cmd && !volt_tif.busy;

  bms_op_timer #(.CYCLES(COPY_CYCLES_P)) u_copy_timer
  (
    .clk   (clk),
    .reset (reset),
    .tif   (copy_tif)
  );

  bms_op_timer #(.CYCLES(CONV_CYCLES_P)) u_volt_timer
  (
    .clk   (clk),
    .reset (reset),
    .tif   (volt_tif)
  );

  // ==========================================================
  // Page three scratchpad and SRAM
  genvar gi;
  generate
    for (gi = 0; gi < BMS_PAGE3_BYTES; gi++)
    begin : g_page3
      always_ff @(posedge clk)
      begin
        if (scratch_write && scratch_index == 3'(gi))
          scratch_mem[gi] <= scratch_data;
        if (copy_page3)
          sram_mem[gi] <= scratch_mem[gi];
      end
    end
  endgenerate

  // ==========================================================
  // Read decode
  function automatic logic [7:0] read_byte(
    input logic [7:0]  addr,
    input logic [15:0] temp,
    input logic [7:0]  status);
    logic [7:0] v;
    v = BMS_UNMAPPED_VALUE;
    if (addr >= BMS_PAGE3_BASE &&
        addr < BMS_PAGE3_BASE + 8'(BMS_PAGE3_BYTES))
      v = sram_mem[addr[2:0]];
    else if (addr == BMS_TEMP_LSB_ADDR)
      v = temp[7:0];
    else if (addr == BMS_TEMP_MSB_ADDR)
      v = temp[15:8];
    else if (addr == BMS_STAT_LSB_ADDR)
      v = status;
    else if (addr == BMS_STAT_MSB_ADDR)
      v = BMS_STAT_MSB_VALUE;
    return v;
  endfunction : read_byte

  logic [7:0] status_lsb;

  // Status byte with upper nibble zero
  always_comb
  begin
    status_lsb               = BMS_BYTE_RESET;
    status_lsb[BMS_TEMP_BUSY_BIT] = st_reg.temp_busy;
    status_lsb[BMS_COPY_BUSY_BIT] = st_reg.copy_busy;
    status_lsb[BMS_LOCK_BIT]      = st_reg.lock;
    status_lsb[BMS_VOLT_BUSY_BIT] = st_reg.volt_busy;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = mem_read;
    if (mem_read)
      st_next.rdata = read_byte(mem_addr, st_reg.temp, status_lsb);
    // Temperature busy and result
    if (temp_conv_done)
    begin
      st_next.temp      = {temp_conv_value, BMS_TEMP_PAD};
      st_next.temp_busy = 1'b0;
    end
    else if (temp_conv_start)
      st_next.temp_busy = 1'b1;
    st_next.copy_busy = copy_tif.busy || copy_tif.start;
    st_next.volt_busy = volt_tif.busy || volt_tif.start;
    st_next.volt_done = volt_tif.done;
    st_next.lock      = first_page_nonvolatile;
  end

  // ==========================================================
  // State register; result is volatile and clears on reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg.rdata     <= BMS_BYTE_RESET;
      st_reg.rvalid    <= 1'b0;
      st_reg.temp      <= 16'h0000;
      st_reg.temp_busy <= 1'b0;
      st_reg.copy_busy <= 1'b0;
      st_reg.volt_busy <= 1'b0;
      st_reg.volt_done <= 1'b0;
      st_reg.lock      <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // Outputs
  assign mem_rdata              = st_reg.rdata;
  assign mem_rvalid             = st_reg.rvalid;
  assign volt_conv_done         = st_reg.volt_done;
  assign temp_conv_busy_flag    = st_reg.temp_busy;
  assign eeprom_copy_busy_flag  = st_reg.copy_busy;
  assign voltage_conv_busy_flag = st_reg.volt_busy;

endmodule : bms_status_pages
`default_nettype wire

// >>> logic/bms_timer_if.sv
// Interface: start/busy handshake for one timed operation
`timescale 1ns/1ns
`default_nettype none
interface bms_timer_if;
  logic start;
  logic busy;
  logic done;
  modport owner (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface : bms_timer_if
`default_nettype wire

// >>> testbench/bms_host_model.sv
// Host model: register reads over the memory port
`timescale 1ns/1ns
`default_nettype none
module bms_host_model
(
  input wire logic       clk, mem_rvalid,
  input wire logic [7:0] mem_rdata,
  output logic           mem_read,
  output logic     [7:0] mem_addr
);
  initial
  begin
    mem_read = 1'b0;
    mem_addr = 8'h00;
  end
  // Request held over the taken edge, answer sampled 1 ns after that same edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 mem_addr = a;
    mem_read = 1'b1;
    @(posedge clk);
    #1 mem_read = 1'b0;
    mem_addr = ~a;
    d = (mem_rvalid === 1'b1) ? mem_rdata : 8'hxx;
  endtask : rd
endmodule : bms_host_model
`default_nettype wire

// >>> testbench/bms_status_props.sv
// Checker: port properties of the status-page block
`timescale 1ns/1ns
`default_nettype none
module bms_status_props
  import bms_pkg::*;
#(
  parameter int COPY_CYCLES_P = 20,
  parameter int CONV_CYCLES_P = 20
)
(
  input wire logic       clk, reset, mem_read, mem_rvalid,
  input wire logic [7:0] mem_addr, mem_rdata,
  input wire logic       temp_conv_start, temp_conv_done,
  input wire logic       volt_conv_done, eeprom_copy_start,
  input wire logic       first_page_nonvolatile, temp_conv_busy_flag,
  input wire logic       eeprom_copy_busy_flag, voltage_conv_busy_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_read_answer: assert property (mem_read |=> mem_rvalid)
    else $error("read not answered");
  a_status_high: assert property (mem_read && mem_addr == 8'h63
    |=> mem_rdata == 8'hff) else $error("status high byte wrong");
  a_status_low: assert property (mem_read && mem_addr == 8'h62
    |=> mem_rdata == {4'h0, $past(voltage_conv_busy_flag),
    $past(first_page_nonvolatile, 2), $past(eeprom_copy_busy_flag),
    $past(temp_conv_busy_flag)}) else $error("status low byte wrong");
  a_temp_busy_set: assert property (temp_conv_start &&
    !temp_conv_done |=> temp_conv_busy_flag)
    else $error("temperature busy not set");
  a_temp_busy_clr: assert property (temp_conv_done
    |=> !temp_conv_busy_flag) else $error("temperature busy not cleared");
  a_copy_busy_set: assert property (eeprom_copy_start &&
    !eeprom_copy_busy_flag |=> eeprom_copy_busy_flag)
    else $error("copy busy not set");
  a_copy_busy_end: assert property ($rose(eeprom_copy_busy_flag)
    |-> eeprom_copy_busy_flag[*8] ##[1:14] !eeprom_copy_busy_flag)
    else $error("copy busy length wrong");
  a_volt_done: assert property ($fell(voltage_conv_busy_flag)
    |-> volt_conv_done) else $error("no done at conversion end");
endmodule : bms_status_props
bind bms_status_pages bms_status_props #(
  .COPY_CYCLES_P(COPY_CYCLES_P), .CONV_CYCLES_P(CONV_CYCLES_P)
) u_props (
  .clk(clk), .reset(reset), .mem_read(mem_read),
  .mem_rvalid(mem_rvalid), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
  .temp_conv_start(temp_conv_start), .temp_conv_done(temp_conv_done),
  .volt_conv_done(volt_conv_done), .eeprom_copy_start(eeprom_copy_start),
  .first_page_nonvolatile(first_page_nonvolatile),
  .temp_conv_busy_flag(temp_conv_busy_flag),
  .eeprom_copy_busy_flag(eeprom_copy_busy_flag),
  .voltage_conv_busy_flag(voltage_conv_busy_flag)
);
`default_nettype wire

// >>> testbench/tb_bms_status_pages.sv
// Testbench: scenarios for the status-page block
`timescale 1ns/1ns
`default_nettype none
module tb_bms_status_pages
  import bms_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, scratch_write = 1'b0, copy_page3 = 1'b0;
  logic temp_conv_start = 1'b0, temp_conv_done = 1'b0, volt_conv_cmd = 1'b0;
  logic eeprom_copy_start = 1'b0, first_page_nonvolatile = 1'b0;
  logic [2:0] scratch_index = 3'h0;
  logic [7:0] scratch_data = 8'h00, mem_addr, mem_rdata;
  logic [12:0] temp_conv_value = 13'h0000;
  logic mem_read, mem_rvalid, volt_conv_done;
  logic temp_conv_busy_flag, eeprom_copy_busy_flag, voltage_conv_busy_flag;
  int errors = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  bms_status_pages #(.COPY_CYCLES_P(20), .CONV_CYCLES_P(20)) dut (
    .clk(clk), .reset(reset), .mem_addr(mem_addr), .mem_read(mem_read),
    .scratch_write(scratch_write), .scratch_index(scratch_index),
    .scratch_data(scratch_data), .copy_page3(copy_page3),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .temp_conv_start(temp_conv_start), .temp_conv_done(temp_conv_done),
    .temp_conv_value(temp_conv_value), .volt_conv_cmd(volt_conv_cmd),
    .volt_conv_done(volt_conv_done), .eeprom_copy_start(eeprom_copy_start),
    .first_page_nonvolatile(first_page_nonvolatile),
    .temp_conv_busy_flag(temp_conv_busy_flag),
    .eeprom_copy_busy_flag(eeprom_copy_busy_flag),
    .voltage_conv_busy_flag(voltage_conv_busy_flag));
  bms_host_model host (.clk(clk), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .mem_read(mem_read), .mem_addr(mem_addr));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask : rc
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask : pulse
  task automatic wait_low(ref logic f, output int n);
    n = 0;
    while (f === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_low
  task automatic t_regs;
    rc(8'h63, 8'hff);
    rc(8'h64, 8'h00);
    rc(8'h62, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_temp;
    logic [15:0] v [3] = '{16'h1910, 16'hff80, 16'he6f0};
    foreach (v[i])
    begin
      temp_conv_value = v[i][15:3];
      pulse(temp_conv_start);
      rc(8'h62, 8'h01);
      pulse(temp_conv_done);
      rc(8'h60, v[i][7:0]);
      rc(8'h61, v[i][15:8]);
      rc(8'h62, 8'h00);
    end
    $display("test temperature done");
  endtask : t_temp
  task automatic t_page3;
    for (int i = 0; i < 8; i++)
    begin
      scratch_index = 3'(i);
      scratch_data = 8'h3c ^ 8'(i);
      pulse(scratch_write);
    end
    pulse(copy_page3);
    for (int i = 0; i < 8; i++)
      rc(8'h40 + 8'(i), 8'h3c ^ 8'(i));
    $display("test page three done");
  endtask : t_page3
  task automatic t_copy;
    int n;
    pulse(eeprom_copy_start);
    rc(8'h62, 8'h02);
    pulse(eeprom_copy_start);
    wait_low(eeprom_copy_busy_flag, n);
    check({7'h0, n > 12 && n < 20}, 8'h01);
    rc(8'h62, 8'h00);
    $display("test copy done");
  endtask : t_copy
  task automatic t_volt;
    int n;
    first_page_nonvolatile = 1'b1;
    pulse(volt_conv_cmd);
    rc(8'h62, 8'h0c);
    wait_low(voltage_conv_busy_flag, n);
    check({7'h0, volt_conv_done}, 8'h01);
    check({7'h0, n > 14 && n < 22}, 8'h01);
    rc(8'h62, 8'h04);
    $display("test voltage done");
  endtask : t_volt
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    t_regs;
    t_temp;
    t_page3;
    t_copy;
    t_volt;
    final_report;
  end
  initial
  begin
    #40000;
    errors++;
    final_report;
  end
endmodule : tb_bms_status_pages
`default_nettype wire
